// [rtl/adc_ctrl_defines.svh]
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define OFS_CTRL_STATUS   8'h70
`define OFS_RESULT_UPPER  8'h71
`define OFS_RESULT_LOWER  8'h72
`define OFS_IRQ_STATUS    8'h74
`define OFS_IRQ_ENABLE    8'h75
`define OFS_IRQ_CLEAR     8'h76
`define BIT_DONE          7
`define BIT_SPEED         6
`define BIT_POWER_ON      5
`define BIT_RESERVED      4
`define CTRL_RESET        8'h00
`define RESULT_RESET      8'h00
`define CONV_CLOCKS       4'hB
`define DIV_FAST          2'h1
`define DIV_SLOW          2'h3
`endif

// [rtl/adc_ctrl_pkg.sv]
// Types shared by the converter control block and its core model
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_START,
        ST_BUSY
    } conv_state_e;
    typedef logic [9:0] result_t;
    typedef logic [3:0] channel_t;
endpackage

// [rtl/adc_sequencer_control.sv]
// Converter control and status registers with continuous conversion sequencing
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_sequencer_control (
    input  wire logic          CORE_CLK,
    input  wire logic          RST_N,
    input  wire logic [7:0]    AVS_ADDRESS,
    input  wire logic          AVS_READ,
    input  wire logic          AVS_WRITE,
    input  wire logic [31:0]   AVS_WRITEDATA,
    input  wire logic [3:0]    AVS_BYTEENABLE,
    output logic      [31:0]   AVS_READDATA,
    output logic               AVS_WAITREQUEST,
    input  wire logic          HALT_MODE,
    input  wire logic          WAIT_MODE,
    input  wire logic [159:0]  SAMPLE_VALUES,
    output logic               CONVERTER_ACTIVE,
    output logic      [3:0]    ANALOG_INPUT_N,
    output logic               IRQ
);
    typedef struct packed {
        adc_ctrl_pkg::conv_state_e state;
        logic                  done;
        logic                  speed;
        logic                  power_on;
        adc_ctrl_pkg::channel_t input_channel_select;
        adc_ctrl_pkg::result_t result;
        logic [1:0]            div_cnt;
        logic                  halt_q1;
        logic                  halt_q2;
        logic                  ack;
        logic [31:0]           rdata;
        logic [1:0]            irq_status;
        logic [1:0]            irq_enable;
    } ctrl_s;

    ctrl_s st_r;
    ctrl_s st_nxt;
    analog_core_if cif ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    analog_core_model core_u (
        .CORE_CLK      (CORE_CLK),
        .RST_N         (RST_N),
        .SAMPLE_VALUES (SAMPLE_VALUES),
        .cif           (cif)
    );

    logic       req;
    logic       wr_ok;
    logic       rd_ok;
    logic       run;
    logic       tick;
    logic [7:0] ctrl_byte;
    logic [1:0] div_end;

    // Request answered one cycle after it appears so read data come from a flip-flop
    assign req   = (AVS_READ || AVS_WRITE) && !st_r.ack;
    // A write lands only at the edge where waitrequest is seen low, never while the master still waits
    assign wr_ok = AVS_WRITE && st_r.ack && AVS_BYTEENABLE[0];
    assign rd_ok = AVS_READ && req;
    // Halt gates the converter off; wait mode is not an input to this logic
    assign run   = st_r.power_on && !st_r.halt_q2;
    assign div_end = st_r.speed ? `DIV_FAST : `DIV_SLOW;
    assign tick  = run && (st_r.div_cnt == div_end);
    assign ctrl_byte = {st_r.done, st_r.speed, st_r.power_on, 1'b0, st_r.input_channel_select};

    always_comb begin
        st_nxt         = st_r;
        st_nxt.halt_q1 = HALT_MODE;
        st_nxt.halt_q2 = st_r.halt_q1;
        st_nxt.ack     = req;
        cif.start      = 1'b0;
        cif.abort      = 1'b0;
        cif.conv_tick  = tick;
        cif.channel    = st_r.input_channel_select;

        if (run) begin
            st_nxt.div_cnt = tick ? 2'h0 : st_r.div_cnt + 2'h1;
        end else begin
            st_nxt.div_cnt = 2'h0;
        end

        if (rd_ok) begin
            st_nxt.rdata = 32'h0;
            if (hit(AVS_ADDRESS, `OFS_CTRL_STATUS)) begin
                st_nxt.rdata[7:0] = ctrl_byte;
            end else if (hit(AVS_ADDRESS, `OFS_RESULT_UPPER)) begin
                st_nxt.rdata[7:0] = st_r.result[9:2];
                st_nxt.done       = 1'b0;
            end else if (hit(AVS_ADDRESS, `OFS_RESULT_LOWER)) begin
                st_nxt.rdata[7:0] = {6'h00, st_r.result[1:0]};
            end else if (hit(AVS_ADDRESS, `OFS_IRQ_STATUS)) begin
                st_nxt.rdata[1:0] = st_r.irq_status;
            end else if (hit(AVS_ADDRESS, `OFS_IRQ_ENABLE)) begin
                st_nxt.rdata[1:0] = st_r.irq_enable;
            end
        end

        if (wr_ok) begin
            if (hit(AVS_ADDRESS, `OFS_CTRL_STATUS)) begin
                // Written done bit is ignored and the write clears done; reserved bit is not stored
                st_nxt.done     = 1'b0;
                st_nxt.speed    = AVS_WRITEDATA[`BIT_SPEED];
                st_nxt.power_on = AVS_WRITEDATA[`BIT_POWER_ON];
                st_nxt.input_channel_select = AVS_WRITEDATA[3:0];
                if (AVS_WRITEDATA[3:0] != st_r.input_channel_select) begin
                    st_nxt.state = adc_ctrl_pkg::ST_START;
                    cif.abort    = 1'b1;
                end
            end else if (hit(AVS_ADDRESS, `OFS_IRQ_ENABLE)) begin
                st_nxt.irq_enable = AVS_WRITEDATA[1:0];
            end else if (hit(AVS_ADDRESS, `OFS_IRQ_CLEAR)) begin
                st_nxt.irq_status = st_r.irq_status & ~AVS_WRITEDATA[1:0];
            end
        end

        if (!run) begin
            st_nxt.state = adc_ctrl_pkg::ST_OFF;
            cif.abort    = 1'b1;
        end else begin
            case (st_r.state)
                adc_ctrl_pkg::ST_OFF: begin
                    st_nxt.state = adc_ctrl_pkg::ST_START;
                end
                adc_ctrl_pkg::ST_START: begin
                    if (!cif.abort) begin
                        cif.start    = 1'b1;
                        st_nxt.state = adc_ctrl_pkg::ST_BUSY;
                    end
                end
                adc_ctrl_pkg::ST_BUSY: begin
                    // A finished result arriving with a channel write is from the old channel; drop it
                    if (cif.done && !cif.abort) begin
                        st_nxt.result = cif.result;
                        st_nxt.done   = 1'b1;
                        st_nxt.state  = adc_ctrl_pkg::ST_START;
                    end
                end
                default: begin
                    st_nxt.state = adc_ctrl_pkg::ST_OFF;
                end
            endcase
        end

        // Sticky events: set wins over clear in the same cycle
        if (cif.done && st_r.state == adc_ctrl_pkg::ST_BUSY && run && !cif.abort) begin
            st_nxt.irq_status[0] = 1'b1;
        end
        if (cif.abort && st_r.state == adc_ctrl_pkg::ST_BUSY && run) begin
            st_nxt.irq_status[1] = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_r       <= '0;
            st_r.state <= adc_ctrl_pkg::ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign AVS_WAITREQUEST  = (AVS_READ || AVS_WRITE) && !st_r.ack;
    assign AVS_READDATA     = st_r.rdata;
    assign CONVERTER_ACTIVE = run;
    assign ANALOG_INPUT_N   = st_r.input_channel_select;
    assign IRQ              = |(st_r.irq_status & st_r.irq_enable);
endmodule

// [rtl/analog_core_if.sv]
// Signals between the sequencer and the abstract analog converter core
`timescale 1ns/1ps
interface analog_core_if;
    logic                  start;
    logic                  abort;
    logic                  conv_tick;
    adc_ctrl_pkg::channel_t channel;
    logic                  done;
    adc_ctrl_pkg::result_t result;
    modport seq  (output start, output abort, output conv_tick, output channel, input done, input result);
    modport core (input start, input abort, input conv_tick, input channel, output done, output result);
endinterface

// [rtl/analog_core_model.sv]
// Abstract successive-approximation core: fixed count of converter clocks, then a result and strobe
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module analog_core_model (
    input  wire logic          CORE_CLK,
    input  wire logic          RST_N,
    input  wire logic [159:0]  SAMPLE_VALUES,
    analog_core_if.core        cif
);
    typedef struct packed {
        logic                  busy;
        logic [3:0]            cnt;
        adc_ctrl_pkg::channel_t ch;
        logic                  done;
        adc_ctrl_pkg::result_t result;
    } core_s;
    core_s st_r;
    core_s st_nxt;
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (cif.abort) begin
            st_nxt.busy = 1'b0;
        end else if (cif.start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = 4'h0;
            st_nxt.ch   = cif.channel;
        end else if (st_r.busy && cif.conv_tick) begin
            if (st_r.cnt == `CONV_CLOCKS - 4'h1) begin
                st_nxt.busy   = 1'b0;
                st_nxt.done   = 1'b1;
                // Result and done registers are the core's only output storage
                st_nxt.result = SAMPLE_VALUES[st_r.ch * 10 +: 10];
            end else begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign cif.done   = st_r.done;
    assign cif.result = st_r.result;
endmodule

// [test/adc_ctrl_monitor.sv]
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_monitor (
    input wire logic         CORE_CLK,
    input wire logic         RST_N,
    input wire logic [7:0]   AVS_ADDRESS,
    input wire logic         AVS_READ,
    input wire logic         AVS_WRITE,
    input wire logic [31:0]  AVS_WRITEDATA,
    input wire logic [3:0]   AVS_BYTEENABLE,
    input wire logic [31:0]  AVS_READDATA,
    input wire logic         AVS_WAITREQUEST,
    input wire logic         HALT_MODE,
    input wire logic         WAIT_MODE,
    input wire logic [159:0] SAMPLE_VALUES,
    input wire logic         CONVERTER_ACTIVE,
    input wire logic [3:0]   ANALOG_INPUT_N,
    input wire logic         IRQ
);
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // A write takes effect at the edge where waitrequest is low
    wire acc_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    wire wr_ctl = acc_wr && AVS_ADDRESS == 8'h70;
    wire rd_ans = AVS_READ && !AVS_WAITREQUEST;
    a_reset_zero: assert property (disable iff (1'b0) !RST_N |=> !AVS_READDATA && !IRQ && !CONVERTER_ACTIVE)
        else $error("outputs not cleared by reset");
    // Halt passes a two-stage synchroniser, hence three samples
    a_halt_stops: assert property (HALT_MODE [*3] |-> !CONVERTER_ACTIVE)
        else $error("converter active during halt");
    a_power_follows: assert property (wr_ctl && !HALT_MODE && !$past(HALT_MODE) && !$past(HALT_MODE, 2)
        |=> CONVERTER_ACTIVE == $past(AVS_WRITEDATA[5]))
        else $error("converter activity does not follow power bit");
    a_channel_follows: assert property (wr_ctl |=> ANALOG_INPUT_N == $past(AVS_WRITEDATA[3:0]))
        else $error("selected input differs from written channel");
    a_answer_next: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered in next cycle");
    a_lower_zero: assert property (rd_ans && AVS_ADDRESS == 8'h72 |-> AVS_READDATA[31:2] == 30'h0)
        else $error("lower result upper bits not zero");
    a_upper_byte: assert property (rd_ans && AVS_ADDRESS == 8'h71 |-> AVS_READDATA[31:8] == 24'h0)
        else $error("upper result wider than a byte");
    a_irq_masked: assert property (acc_wr && AVS_ADDRESS == 8'h75 && AVS_WRITEDATA[1:0] == 2'h0 |=> !IRQ)
        else $error("interrupt raised while masked");
    c_power_on: cover property (wr_ctl && AVS_WRITEDATA[5]);
    c_halt: cover property (HALT_MODE [*3]);
    c_irq: cover property (IRQ);
endmodule
bind adc_sequencer_control adc_ctrl_monitor u_mon (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HALT_MODE(HALT_MODE),
    .WAIT_MODE(WAIT_MODE), .SAMPLE_VALUES(SAMPLE_VALUES), .CONVERTER_ACTIVE(CONVERTER_ACTIVE),
    .ANALOG_INPUT_N(ANALOG_INPUT_N), .IRQ(IRQ));

// [test/analog_source_model.sv]
// Analog input stand-in: a fixed, distinct level on each of the sixteen inputs
`timescale 1ns/1ps
module analog_source_model (
    output logic [159:0] SAMPLE_VALUES
);
    // Distinct upper eight bits per input, so a wrong mux pick always shows in the upper result register
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            SAMPLE_VALUES[n*10 +: 10] = 10'(n * 67 + 3);
        end
    end
endmodule

// [test/tb_adc_sequencer_control.sv]
// Self-checking bench: register accesses drive conversions and interrupts; halt and wait are driven on their mode inputs
`timescale 1ns/1ps
module tb_adc_sequencer_control;
    logic         clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, halt = 1'b0, waitm = 1'b0;
    logic [7:0]   addr = 8'h00;
    logic [31:0]  wdata = 32'h0, rdata, rd;
    logic         waitreq, active, irq, spd;
    logic [159:0] samples;
    logic [3:0]   chan, ch;
    logic [9:0]   val;
    int           errors = 0, num_checks = 0, cycles = 0, t0;
    always #5 clk = ~clk;
    analog_source_model u_src (.SAMPLE_VALUES(samples));
    adc_sequencer_control DUT (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .HALT_MODE(halt), .WAIT_MODE(waitm), .SAMPLE_VALUES(samples),
        .CONVERTER_ACTIVE(active), .ANALOG_INPUT_N(chan), .IRQ(irq));
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds the request until waitrequest is sampled low; the leading edge keeps strobes from re-rising at once
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        rd_en <= !wr;
        wr_en <= wr;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic wait_done();
        do bus(1'b0, 8'h70, 8'h00); while (rd[7] !== 1'b1);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 8'(8'h70 + i), 8'h00);
            chk("reset_value", 32'h0, rd);
        end
        bus(1'b1, 8'h75, 8'h01);
        // Each pass after the first changes channel while the previous one is still converting
        for (int i = 0; i < 4; i++) begin
            ch = 4'(i * 5);
            spd = i[0];
            val = 10'(ch * 67 + 3);
            bus(1'b1, 8'h70, {1'b0, spd, 2'b10, ch});
            t0 = cycles;
            wait_done();
            chk("conv_time", 32'h1, {31'h0, spd ? (cycles - t0 < 34) : (cycles - t0 >= 40)});
            chk("irq", 32'h1, {31'h0, irq});
            bus(1'b0, 8'h72, 8'h00);
            chk("lower", {30'h0, val[1:0]}, rd);
            bus(1'b0, 8'h71, 8'h00);
            chk("upper", {24'h0, val[9:2]}, rd);
            bus(1'b0, 8'h70, 8'h00);
            chk("ctrl", {24'h0, 1'b0, spd, 2'b10, ch}, rd);
            chk("channel", {28'h0, ch}, {28'h0, chan});
        end
        halt <= 1'b1;
        repeat (4) @(posedge clk);
        chk("halted", 32'h0, {31'h0, active});
        halt <= 1'b0;
        waitm <= 1'b1;
        repeat (4) @(posedge clk);
        chk("waiting", 32'h1, {31'h0, active});
        bus(1'b0, 8'h71, 8'h00);
        wait_done();
        bus(1'b0, 8'h71, 8'h00);
        chk("repeat_upper", {24'h0, val[9:2]}, rd);
        bus(1'b1, 8'h70, {1'b1, spd, 2'b10, ch});
        bus(1'b0, 8'h70, 8'h00);
        chk("done_readonly", {24'h0, 1'b0, spd, 2'b10, ch}, rd);
        bus(1'b0, 8'h74, 8'h00);
        chk("irq_status", 32'h3, rd);
        bus(1'b0, 8'h75, 8'h00);
        chk("irq_enable", 32'h1, rd);
        bus(1'b1, 8'h70, {4'h0, ch});
        // A write lands on the edge the task returns at, so each check trails its write by one access
        bus(1'b1, 8'h75, 8'h00);
        chk("off", 32'h0, {31'h0, active});
        bus(1'b1, 8'h76, 8'h03);
        chk("irq_masked", 32'h0, {31'h0, irq});
        bus(1'b1, 8'h75, 8'h03);
        bus(1'b0, 8'h74, 8'h00);
        chk("irq_status_clr", 32'h0, rd);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        bus(1'b0, 8'h73, 8'h00);
        chk("unmapped", 32'h0, rd);
        final_report();
    end
endmodule
